// *** oms_map.svh ***
// register offsets, field positions, reset values and mode codes of the
// one-shot and monostable timer; definitions only, no logic.
// assumes it is included by its bare name from the design and the bench.
`ifndef OMS_MAP_SVH
`define OMS_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define OMS_ADDR_COUNT 3'h0
`define OMS_ADDR_PERIOD 3'h1
`define OMS_ADDR_WIDTH 3'h2
`define OMS_ADDR_CTRL 3'h3
`define OMS_ADDR_HLT 3'h4
// ****************************************
// fields and reset values
// ****************************************
`define OMS_CTRL_RUN_BIT 7
`define OMS_HLT_SYNC_BIT 7
`define OMS_HLT_MODE_MSB 4
`define OMS_RST_BYTE 8'h00
`define OMS_RST_MODE 5'h00
// restart delay after an external reset edge, in timer clocks
`define OMS_RESTART_CLOCKS 2
`define OMS_RESTART_HOLD 2'h1
// ****************************************
// mode codes
// ****************************************
`define OMS_MODE_SW 5'h08
`define OMS_MODE_EOS_R 5'h09
`define OMS_MODE_EOS_F 5'h0A
`define OMS_MODE_EOS_A 5'h0B
`define OMS_MODE_HLE_R 5'h0C
`define OMS_MODE_HLE_F 5'h0D
`define OMS_MODE_LRE_L 5'h0E
`define OMS_MODE_LRE_H 5'h0F
`define OMS_MODE_MONO_R 5'h11
`define OMS_MODE_MONO_F 5'h12
`define OMS_MODE_MONO_A 5'h13
`define OMS_MODE_LHL_L 5'h16
`define OMS_MODE_LHL_H 5'h17
`endif

// *** oms_pkg.sv ***
// types shared by the timer and its bench.
// assumes oms_map.svh carries every register and mode number; the class codes stand here.
package oms_pkg;
  typedef enum logic [2:0] {
    OMS_IDLE = 3'b000,
    OMS_SWOS = 3'b001,
    OMS_EDGEOS = 3'b010,
    OMS_HLEDGE = 3'b011,
    OMS_LVLEDGE = 3'b100,
    OMS_MONO = 3'b101,
    OMS_LVLHL = 3'b110
  } oms_class_e;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } oms_bus_s;
  typedef struct packed {
    logic period;
    logic width;
  } oms_match_s;
endpackage

// *** oms_timer.sv ***
// one-shot, edge, hardware-limit and monostable period timer with a
// double-buffered period and pulse drive for the pwm unit.
// assumes a plain register port on clock_i and an asynchronous trigger pin.
//
// The plain strobed port and the register addresses were decided locally.
`include "oms_map.svh"
module oms_timer
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire oms_pkg::oms_bus_s bus_i,
  input wire logic sleep_i,
  input wire logic external_reset_trigger_i,
  output logic [7:0] rd_data_o,
  output logic pulse_drive_o,
  output oms_pkg::oms_match_s match_o,
  output logic keep_osc_o
);
  // ****************************************
  // declarations
  // ****************************************
  logic ers_meta, ers_sync, ers_prev, rise, fall, run, go, freeze;
  logic prescaler_output_sync, hw_clr, start_ev, ext_rst, load_buf;
  logic [4:0] mode;
  logic [7:0] count_value, period_reg_visible, period_value;
  logic [7:0] pulse_width_value, next_count;
  logic [1:0] hold, next_hold;
  logic wr_count, wr_period, wr_width, wr_ctrl, wr_hlt, next_go;
  oms_pkg::oms_class_e cls;
  logic sel_rise, sel_fall, rst_high, qual, at_reset, at_match, width_hit;
  // ****************************************
  // trigger pin synchroniser and edges
  // ****************************************
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ers_meta <= 1'b0;
      ers_sync <= 1'b0;
      ers_prev <= 1'b0;
    end
    else
    begin
      ers_meta <= external_reset_trigger_i;
      ers_sync <= ers_meta;
      ers_prev <= ers_sync;
    end
  end
  assign rise = ers_sync & ~ers_prev;
  assign fall = ~ers_sync & ers_prev;
  // ****************************************
  // register strobes
  // ****************************************
  assign wr_count = bus_i.wr && (bus_i.addr == `OMS_ADDR_COUNT);
  assign wr_period = bus_i.wr && (bus_i.addr == `OMS_ADDR_PERIOD);
  assign wr_width = bus_i.wr && (bus_i.addr == `OMS_ADDR_WIDTH);
  assign wr_ctrl = bus_i.wr && (bus_i.addr == `OMS_ADDR_CTRL);
  assign wr_hlt = bus_i.wr && (bus_i.addr == `OMS_ADDR_HLT);
  // timer stands still in sleep only with the synced prescaler
  assign freeze = sleep_i & prescaler_output_sync;
  // ****************************************
  // mode decode
  // ****************************************
  always_comb
  begin
    cls = oms_pkg::OMS_IDLE;
    sel_rise = 1'b0;
    sel_fall = 1'b0;
    rst_high = 1'b0;
    // unlisted codes stay idle
    case (mode)
      `OMS_MODE_SW: cls = oms_pkg::OMS_SWOS;
      `OMS_MODE_EOS_R, `OMS_MODE_EOS_F, `OMS_MODE_EOS_A:
      begin
        cls = oms_pkg::OMS_EDGEOS;
        sel_rise = (mode != `OMS_MODE_EOS_F);
        sel_fall = (mode != `OMS_MODE_EOS_R);
      end
      `OMS_MODE_HLE_R, `OMS_MODE_HLE_F:
      begin
        cls = oms_pkg::OMS_HLEDGE;
        sel_rise = (mode == `OMS_MODE_HLE_R);
        sel_fall = (mode == `OMS_MODE_HLE_F);
      end
      `OMS_MODE_LRE_L, `OMS_MODE_LRE_H:
      begin
        cls = oms_pkg::OMS_LVLEDGE;
        rst_high = (mode == `OMS_MODE_LRE_H);
        sel_rise = ~rst_high;
        sel_fall = rst_high;
      end
      `OMS_MODE_MONO_R, `OMS_MODE_MONO_F, `OMS_MODE_MONO_A:
      begin
        cls = oms_pkg::OMS_MONO;
        sel_rise = (mode != `OMS_MODE_MONO_F);
        sel_fall = (mode != `OMS_MODE_MONO_R);
      end
      `OMS_MODE_LHL_L, `OMS_MODE_LHL_H:
      begin
        cls = oms_pkg::OMS_LVLHL;
        rst_high = (mode == `OMS_MODE_LHL_H);
      end
      default: cls = oms_pkg::OMS_IDLE;
    endcase
  end
  assign qual = (sel_rise & rise) | (sel_fall & fall);
  assign at_reset = rst_high ? ers_sync : ~ers_sync;
  // compare the period against the hidden buffer, never the visible copy
  assign at_match = go && (hold == 2'h0) && (count_value == period_value);
  assign width_hit = go && (hold == 2'h0) &&
    (count_value == pulse_width_value);
  // ****************************************
  // start and reset state machine
  // ****************************************
  always_comb
  begin
    next_go = go;
    start_ev = 1'b0;
    ext_rst = 1'b0;
    unique case (cls)
      oms_pkg::OMS_IDLE: next_go = 1'b0;
      oms_pkg::OMS_SWOS:
      begin
        next_go = run;
        start_ev = run & ~go & (count_value == 8'h00);
      end
      oms_pkg::OMS_EDGEOS, oms_pkg::OMS_MONO:
      begin
        // a rerun waits for a new edge
        if (!run)
          next_go = 1'b0;
        else if (!go && qual)
        begin
          next_go = 1'b1;
          start_ev = 1'b1;
        end
      end
      oms_pkg::OMS_HLEDGE:
      begin
        // edges have no effect while stopped
        if (!run)
          next_go = 1'b0;
        else if (qual)
        begin
          next_go = 1'b1;
          ext_rst = go;
          start_ev = ~go;
        end
      end
      oms_pkg::OMS_LVLEDGE:
      begin
        if (at_reset)
        begin
          next_go = 1'b0;
          ext_rst = run;
        end
        else if (!run)
          next_go = 1'b0;
        else if (!go && qual)
        begin
          next_go = 1'b1;
          start_ev = 1'b1;
        end
      end
      oms_pkg::OMS_LVLHL:
      begin
        // either order of run and level starts the count
        next_go = run & ~at_reset;
        start_ev = run & ~at_reset & ~go;
        ext_rst = run & at_reset;
      end
    endcase
  end
  // ****************************************
  // counter next value
  // ****************************************
  always_comb
  begin
    next_count = count_value;
    next_hold = hold;
    hw_clr = 1'b0;
    if (cls == oms_pkg::OMS_IDLE)
      next_count = 8'h00;
    else if (ext_rst)
    begin
      next_count = 8'h00;
      if (cls == oms_pkg::OMS_HLEDGE)
        next_hold = `OMS_RESTART_HOLD;
    end
    else if (go && hold != 2'h0)
      next_hold = hold - 2'h1;
    else if (at_match)
    begin
      next_count = 8'h00;
      // monostable keeps run set
      hw_clr = (cls != oms_pkg::OMS_MONO);
    end
    else if (go && (run || cls == oms_pkg::OMS_SWOS ||
      cls == oms_pkg::OMS_EDGEOS))
      next_count = count_value + 8'h01;
    else if (cls != oms_pkg::OMS_SWOS && cls != oms_pkg::OMS_EDGEOS)
      next_count = 8'h00;
  end
  // ****************************************
  // timer state
  // ****************************************
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_value <= `OMS_RST_BYTE;
      go <= 1'b0;
      hold <= 2'h0;
    end
    else if (wr_count)
    begin
      count_value <= bus_i.wdata;
      hold <= 2'h0;
    end
    else if (!freeze)
    begin
      count_value <= next_count;
      go <= (at_match && !ext_rst) ? 1'b0 : next_go;
      hold <= next_hold;
    end
  end
  // a software write wins over the hardware clear of the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run <= 1'b0;
    else if (wr_ctrl)
      run <= bus_i.wdata[`OMS_CTRL_RUN_BIT];
    else if (hw_clr && !freeze)
      run <= 1'b0;
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode <= `OMS_RST_MODE;
      prescaler_output_sync <= 1'b0;
    end
    else if (wr_hlt)
    begin
      mode <= bus_i.wdata[`OMS_HLT_MODE_MSB:0];
      prescaler_output_sync <= bus_i.wdata[`OMS_HLT_SYNC_BIT];
    end
  end
  // ****************************************
  // period and width registers
  // ****************************************
  // prescaler is fixed at one to one, so every match is a rollover
  assign load_buf = wr_count | wr_ctrl | wr_hlt |
    (!freeze & (at_match | ext_rst));
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      period_reg_visible <= `OMS_RST_BYTE;
      pulse_width_value <= `OMS_RST_BYTE;
    end
    else
    begin
      if (wr_period)
        period_reg_visible <= bus_i.wdata;
      if (wr_width)
        pulse_width_value <= bus_i.wdata;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      period_value <= `OMS_RST_BYTE;
    else if (load_buf)
      period_value <= period_reg_visible;
  end
  // ****************************************
  // pulse drive and match outputs
  // ****************************************
  // run clear leaves the drive alone, which stretches the pulse
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pulse_drive_o <= 1'b0;
    else if (cls == oms_pkg::OMS_IDLE)
      pulse_drive_o <= 1'b0;
    else if (!freeze)
    begin
      if (start_ev || (ext_rst && cls == oms_pkg::OMS_HLEDGE))
        pulse_drive_o <= 1'b1;
      else if (width_hit)
        pulse_drive_o <= 1'b0;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      match_o <= '0;
      keep_osc_o <= 1'b0;
    end
    else
    begin
      match_o.period <= at_match & ~freeze & ~wr_count;
      match_o.width <= width_hit & ~freeze & ~wr_count;
      keep_osc_o <= sleep_i & ~prescaler_output_sync;
    end
  end
  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_data_o <= `OMS_RST_BYTE;
    else if (!bus_i.rd)
      rd_data_o <= `OMS_RST_BYTE;
    else
    begin
      case (bus_i.addr)
        `OMS_ADDR_COUNT: rd_data_o <= count_value;
        `OMS_ADDR_PERIOD: rd_data_o <= period_reg_visible;
        `OMS_ADDR_WIDTH: rd_data_o <= pulse_width_value;
        `OMS_ADDR_CTRL: rd_data_o <= {run, 7'h00};
        `OMS_ADDR_HLT: rd_data_o <= {prescaler_output_sync, 2'h0, mode};
        default: rd_data_o <= `OMS_RST_BYTE;
      endcase
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_sw_match;
    (cls == oms_pkg::OMS_SWOS) && at_match && !freeze && !bus_i.wr
      |=> !run && (count_value == 8'h00);
  endproperty
  a_sw_match: assert property (p_sw_match)
    else $error("software one-shot did not stop at period");
  property p_edge_wait;
    (cls == oms_pkg::OMS_EDGEOS) && !go && !qual && !bus_i.wr
      |=> $stable(count_value) && !go;
  endproperty
  a_edge_wait: assert property (p_edge_wait)
    else $error("edge one-shot counted without an edge");
  property p_restart;
    (cls == oms_pkg::OMS_HLEDGE) && go && run && qual && !freeze &&
      !bus_i.wr
      |=> (count_value == 8'h00) && (hold == `OMS_RESTART_HOLD);
  endproperty
  a_restart: assert property (p_restart)
    else $error("reset edge did not clear and delay the count");
  property p_level_hold;
    (cls == oms_pkg::OMS_LVLEDGE) && at_reset && !freeze && !bus_i.wr
      |=> (count_value == 8'h00) && !go;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("count not held at the reset level");
  property p_mono_stop;
    (cls == oms_pkg::OMS_MONO) && at_match && !freeze && !bus_i.wr
      |=> (count_value == 8'h00) && run && !go;
  endproperty
  a_mono_stop: assert property (p_mono_stop)
    else $error("monostable did not stop at zero with run kept");
  property p_lvlhl_off;
    (cls == oms_pkg::OMS_LVLHL) && !run && !freeze && !bus_i.wr
      |=> (count_value == 8'h00) ##1 (count_value == 8'h00) || go;
  endproperty
  a_lvlhl_off: assert property (p_lvlhl_off)
    else $error("level limit count left reset while stopped");
  property p_width_off;
    width_hit && !start_ev && !ext_rst && !freeze &&
      (cls != oms_pkg::OMS_IDLE)
      |=> !pulse_drive_o;
  endproperty
  a_width_off: assert property (p_width_off)
    else $error("pulse drive stayed on past the width match");
  property p_buf_hidden;
    !load_buf |=> (period_value == $past(period_value));
  endproperty
  a_buf_hidden: assert property (p_buf_hidden)
    else $error("period buffer changed without a load event");
  property p_sleep_freeze;
    freeze && !bus_i.wr
      |=> $stable(count_value) && $stable(period_value);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("timer moved in sleep with synced prescaler");
  property p_match_out;
    match_o.period == ($past(at_match) && !$past(freeze) &&
      !$past(wr_count));
  endproperty
  a_match_out: assert property (p_match_out)
    else $error("period match indication out of step");
  property p_reserved;
    (cls == oms_pkg::OMS_IDLE) && !bus_i.wr
      |=> (count_value == 8'h00) && !pulse_drive_o;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved mode did not hold the counter idle");
endmodule

// *** oms_far_end.sv ***
// trigger source on the timer's reset/trigger pin.
// assumes one clock shared with the timer; the bench calls level().
module oms_far_end
(
  input wire logic clock_i,
  input wire logic pulse_drive_i,
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // pin driver
  // ****************************************
  // four cycles a level: the timer's synchroniser needs two
  task automatic level(input logic v);
    @(posedge clock_i);
    trig_o <= v;
    repeat (4) @(posedge clock_i);
  endtask
  initial
  begin
    trig_o = 1'b0;
  end
endmodule

// *** tb.sv ***
// self-checking bench of the one-shot and monostable timer.
// assumes oms_timer, oms_pkg and the trigger source model.
`include "oms_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, sleep_i, trig, drive, keep_osc, idle;
  oms_pkg::oms_bus_s bus;
  oms_pkg::oms_match_s match;
  logic [7:0] rd_data, v, w;
  logic [4:0] m;
  int fails, tests_run, i;
  logic [4:0] modes [6] = '{`OMS_MODE_EOS_R, `OMS_MODE_EOS_F,
    `OMS_MODE_EOS_A, `OMS_MODE_MONO_R, `OMS_MODE_MONO_F, `OMS_MODE_MONO_A};
  oms_timer DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus),
    .sleep_i(sleep_i), .external_reset_trigger_i(trig),
    .rd_data_o(rd_data), .pulse_drive_o(drive), .match_o(match),
    .keep_osc_o(keep_osc));
  oms_far_end P (.clock_i(clock_i), .pulse_drive_i(drive), .trig_o(trig));
  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic conclude;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rchk(input string n, input logic [2:0] a,
                      input logic [7:0] e);
    rd(a, v);
    chk(n, e, v);
  endtask
  task automatic arm(input logic [7:0] md, input logic [7:0] p,
                     input logic [7:0] wd, input logic [7:0] run);
    wr(`OMS_ADDR_CTRL, 8'h00);
    wr(`OMS_ADDR_WIDTH, wd);
    wr(`OMS_ADDR_PERIOD, p);
    wr(`OMS_ADDR_HLT, md);
    wr(`OMS_ADDR_CTRL, run);
  endtask
  // bounded wait for a match pulse; sel 1 is the width match
  task automatic wait_match(input bit sel, input int lim);
    int k;
    #1;
    k = 0;
    while (k < lim && (sel ? match.width : match.period) !== 1'b1)
    begin
      @(posedge clock_i);
      #1 k++;
    end
    chk("match in time", 8'h01, 8'(k < lim));
  endtask
  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial
  begin
    #200000;
    fails++;
    conclude();
  end
  initial
  begin
    fails = 0;
    tests_run = 0;
    bus = '0;
    sleep_i = 1'b0;
    rst_n_i = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 6; i++)
      rchk("reset value", i[2:0], 8'h00);
    wr(`OMS_ADDR_PERIOD, 8'hA5);
    rchk("period visible", `OMS_ADDR_PERIOD, 8'hA5);
    arm({3'h0, `OMS_MODE_SW}, 8'h14, 8'h0A, 8'h80);
    repeat (2) @(posedge clock_i);
    chk("drive at start", 8'h01, 8'(drive));
    wr(`OMS_ADDR_CTRL, 8'h00);
    rd(`OMS_ADDR_COUNT, w);
    repeat (4) @(posedge clock_i);
    rchk("paused count", `OMS_ADDR_COUNT, w);
    chk("drive extended", 8'h01, 8'(drive));
    wr(`OMS_ADDR_CTRL, 8'h80);
    wait_match(1'b1, 40);
    wait_match(1'b0, 40);
    rchk("run cleared", `OMS_ADDR_CTRL, 8'h00);
    rchk("count cleared", `OMS_ADDR_COUNT, 8'h00);
    chk("drive off", 8'h00, 8'(drive));
    wr(`OMS_ADDR_CTRL, 8'h80);
    wait_match(1'b0, 40);
    // buffered period keeps the old value until a load event
    wr(`OMS_ADDR_PERIOD, 8'h0C);
    wr(`OMS_ADDR_CTRL, 8'h80);
    wr(`OMS_ADDR_PERIOD, 8'h5A);
    wait_match(1'b0, 14);
    rchk("visible copy", `OMS_ADDR_PERIOD, 8'h5A);
    // a count write alone must pull the short period into the buffer
    wr(`OMS_ADDR_CTRL, 8'h80);
    wr(`OMS_ADDR_PERIOD, 8'h05);
    wr(`OMS_ADDR_COUNT, 8'h00);
    wait_match(1'b0, 10);
    for (i = 0; i < 6; i++)
    begin
      m = modes[i];
      idle = (m == `OMS_MODE_EOS_F) || (m == `OMS_MODE_MONO_F);
      P.level(idle);
      arm({3'h0, m}, 8'h06, 8'h02, 8'h80);
      rchk("no edge yet", `OMS_ADDR_COUNT, 8'h00);
      P.level(~idle);
      wait_match(1'b0, 40);
      rchk("run after match", `OMS_ADDR_CTRL, {m[4], 7'h00});
      rchk("count at match", `OMS_ADDR_COUNT, 8'h00);
      chk("drive after match", 8'h00, 8'(drive));
    end
    P.level(1'b0);
    arm({3'h0, `OMS_MODE_EOS_R}, 8'hC8, 8'h02, 8'h80);
    P.level(1'b1);
    wr(`OMS_ADDR_CTRL, 8'h00);
    wr(`OMS_ADDR_CTRL, 8'h80);
    rd(`OMS_ADDR_COUNT, w);
    repeat (4) @(posedge clock_i);
    rchk("waits for edge", `OMS_ADDR_COUNT, w);
    P.level(1'b0);
    P.level(1'b1);
    rd(`OMS_ADDR_COUNT, v);
    chk("resumed", 8'h01, 8'(v != w));
    for (i = 0; i < 2; i++)
    begin
      idle = i[0];
      P.level(idle);
      arm({3'h0, `OMS_MODE_HLE_R + 5'(i)}, 8'hC8, 8'h05, 8'h00);
      P.level(~idle);
      P.level(idle);
      rchk("edges ignored", `OMS_ADDR_COUNT, 8'h00);
      wr(`OMS_ADDR_CTRL, 8'h80);
      P.level(~idle);
      P.level(idle);
      repeat (6) @(posedge clock_i);
      chk("drive ended", 8'h00, 8'(drive));
      P.level(~idle);
      chk("drive on reset", 8'h01, 8'(drive));
      rd(`OMS_ADDR_COUNT, v);
      chk("count limited", 8'h01, 8'(v < 8'h06));
    end
    for (i = 0; i < 2; i++)
    begin
      idle = i[0];
      P.level(idle);
      arm({3'h0, `OMS_MODE_LRE_L + 5'(i)}, 8'h08, 8'h03, 8'h80);
      repeat (4) @(posedge clock_i);
      rchk("held at level", `OMS_ADDR_COUNT, 8'h00);
      P.level(~idle);
      chk("drive on edge", 8'h01, 8'(drive));
      wait_match(1'b0, 40);
      chk("no drive at period", 8'h00, 8'(drive));
      rchk("run cleared", `OMS_ADDR_CTRL, 8'h00);
      wr(`OMS_ADDR_CTRL, 8'h80);
      repeat (4) @(posedge clock_i);
      rchk("needs new edge", `OMS_ADDR_COUNT, 8'h00);
    end
    for (i = 0; i < 2; i++)
    begin
      idle = i[0];
      P.level(~idle);
      arm({3'h0, `OMS_MODE_LHL_L + 5'(i)}, 8'h3C, 8'h1E, 8'h80);
      repeat (3) @(posedge clock_i);
      rd(`OMS_ADDR_COUNT, v);
      chk("run starts", 8'h01, 8'(v != 8'h00));
      chk("drive on run", 8'h01, 8'(drive));
      P.level(idle);
      rchk("held in reset", `OMS_ADDR_COUNT, 8'h00);
      P.level(~idle);
      wait_match(1'b0, 100);
      rchk("run cleared", `OMS_ADDR_CTRL, 8'h00);
      repeat (3) @(posedge clock_i);
      rchk("stays reset", `OMS_ADDR_COUNT, 8'h00);
    end
    arm(8'h10, 8'h05, 8'h02, 8'h80);
    repeat (6) @(posedge clock_i);
    rchk("reserved idle", `OMS_ADDR_COUNT, 8'h00);
    chk("reserved drive", 8'h00, 8'(drive));
    // synced prescaler: frozen in sleep, no oscillator request
    arm(8'h88, 8'hC8, 8'h02, 8'h80);
    @(posedge clock_i);
    sleep_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rd(`OMS_ADDR_COUNT, w);
    repeat (4) @(posedge clock_i);
    rchk("frozen count", `OMS_ADDR_COUNT, w);
    chk("no osc keep", 8'h00, 8'(keep_osc));
    @(posedge clock_i);
    sleep_i <= 1'b0;
    arm({3'h0, `OMS_MODE_SW}, 8'hC8, 8'h02, 8'h80);
    @(posedge clock_i);
    sleep_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rd(`OMS_ADDR_COUNT, w);
    rd(`OMS_ADDR_COUNT, v);
    chk("runs in sleep", 8'h01, 8'(v != w));
    chk("osc kept", 8'h01, 8'(keep_osc));
    @(posedge clock_i);
    sleep_i <= 1'b0;
    conclude();
  end
endmodule
